// *** rtl/cpf_fsm.sv ***
// protection-mode state machine with wishbone register slave
//
// Our own choices: the Wishbone interface to the registers and the register offsets.
`timescale 1ns/10ps
`include "cpf_defines.svh"

// Summary of operation
// - in normal mode both charge and discharge switches stay on
// - sense above short threshold for whole short delay: discharge off, enter short mode
// - while in short mode the sense pull-down is enabled
// - leave short mode after load gone and sense low for release delay
// - sense below charge over-current level for its delay: charge off, enter mode
// - leave charge over-current mode after charger gone for release delay
// - charger removal alone releases; sense comparison is not required
// - zero-volt charging: charger detected turns charge switch on
// - zero-volt charging keeps discharge switch off
// - cell reaching over-discharge release voltage ends zero-volt charging
module cpf_fsm #(
  parameter int SC_DLY_CYC = `CPF_SC_DLY_CYC,
  parameter int DIS_REL_DLY_CYC = `CPF_DIS_REL_DLY_CYC,
  parameter int OC_DLY_CYC = `CPF_OC_DLY_CYC,
  parameter int OC_REL_DLY_CYC = `CPF_OC_REL_DLY_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone classic slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // comparator and presence inputs, asynchronous
  input wire logic sense_ge_short_i,
  input wire logic sense_le_dis_release_i,
  input wire logic sense_le_chg_oc_i,
  input wire logic charger_present_i,
  input wire logic load_present_i,
  input wire logic cell_below_uv_i,
  input wire logic cell_ge_uv_release_i,
  input wire logic charger_ge_detect_i,
  // power switch and pull-down controls, and the interrupt output
  output logic charge_switch_o,
  output logic discharge_switch_o,
  output logic sense_pulldown_o,
  output logic irq_o
);

  // number of synchronised inputs
  localparam int NIN = 8;

  // ==========================================================
  // input synchronisers, three stages with agreement filter
  logic [NIN-1:0] raw;
  logic [NIN-1:0] s1_r;
  logic [NIN-1:0] s2_r;
  logic [NIN-1:0] s3_r;
  logic [NIN-1:0] in_r;

  assign raw = {charger_ge_detect_i, cell_ge_uv_release_i, cell_below_uv_i,
                load_present_i, charger_present_i, sense_le_chg_oc_i,
                sense_le_dis_release_i, sense_ge_short_i};

  // shift chain, first stage read only by the second
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
    end else begin
      s1_r <= raw;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // accept a change once stages two and three agree
  // a one-cycle glitch on a pin never reaches the timers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      in_r <= '0;
    end else begin
      for (int i = 0; i < NIN; i++) begin
        if (s2_r[i] == s3_r[i]) begin
          in_r[i] <= s3_r[i];
        end
      end
    end
  end

  logic sc_hi;
  logic dis_rel_lo;
  logic oc_lo;
  logic chg_in;
  logic load_in;
  logic uv_in;
  logic uvr_in;
  logic chg_det;

  // filtered conditions, in the bit order of raw
  assign sc_hi = in_r[0];
  assign dis_rel_lo = in_r[1];
  assign oc_lo = in_r[2];
  assign chg_in = in_r[3];
  assign load_in = in_r[4];
  assign uv_in = in_r[5];
  assign uvr_in = in_r[6];
  assign chg_det = in_r[7];

  // ==========================================================
  // delay timers
  logic ctrl_zv_en_r;
  cpf_pkg::cpf_state_t state_r;
  cpf_pkg::cpf_state_t state_nxt;
  cpf_pkg::cpf_cnt_t sc_cnt_r;
  cpf_pkg::cpf_cnt_t oc_cnt_r;
  cpf_pkg::cpf_cnt_t rel_cnt_r;
  logic sc_run;
  logic oc_run;
  logic rel_run;
  logic sc_done;
  logic oc_done;
  logic rel_done;

  // count while held, restart from zero when dropped
  function automatic cpf_pkg::cpf_cnt_t tmr_next(input logic run,
                                                 input cpf_pkg::cpf_cnt_t cnt);
    tmr_next = run ? cpf_pkg::cpf_cnt_t'(cnt + 24'h000001) : 24'h000000;
  endfunction

  // condition held for the full count of cycles
  function automatic logic tmr_done(input logic run, input cpf_pkg::cpf_cnt_t cnt,
                                    input int lim);
    tmr_done = run && (cnt == cpf_pkg::cpf_cnt_t'(lim - 1));
  endfunction

  // detection timers run only in normal mode
  assign sc_run = (state_r == cpf_pkg::CPF_NORMAL) && sc_hi;
  assign oc_run = (state_r == cpf_pkg::CPF_NORMAL) && oc_lo;
  // release needs load gone and sense low; charger gone alone suffices
  assign rel_run = (state_r == cpf_pkg::CPF_SHORT) ? (!load_in && dis_rel_lo)
                 : (state_r == cpf_pkg::CPF_CHG_OC) ? !chg_in
                 : 1'b0;
  assign sc_done = tmr_done(sc_run, sc_cnt_r, SC_DLY_CYC);
  assign oc_done = tmr_done(oc_run, oc_cnt_r, OC_DLY_CYC);
  assign rel_done = tmr_done(rel_run, rel_cnt_r,
                             (state_r == cpf_pkg::CPF_SHORT) ? DIS_REL_DLY_CYC
                                                             : OC_REL_DLY_CYC);

  // timers restart on any drop or mode change
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sc_cnt_r <= '0;
      oc_cnt_r <= '0;
      rel_cnt_r <= '0;
    end else begin
      sc_cnt_r <= sc_done ? 24'h000000 : tmr_next(sc_run, sc_cnt_r);
      oc_cnt_r <= oc_done ? 24'h000000 : tmr_next(oc_run, oc_cnt_r);
      rel_cnt_r <= rel_done ? 24'h000000 : tmr_next(rel_run, rel_cnt_r);
    end
  end

  // ==========================================================
  // mode selection, short has priority over charge over-current
  // zero-volt entry also needs the enable bit of ctrl
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      cpf_pkg::CPF_NORMAL: begin
        if (sc_done) begin
          state_nxt = cpf_pkg::CPF_SHORT;
        end else if (oc_done) begin
          state_nxt = cpf_pkg::CPF_CHG_OC;
        end else if (uv_in && ctrl_zv_en_r) begin
          state_nxt = cpf_pkg::CPF_ZERO_V;
        end
      end
      cpf_pkg::CPF_SHORT: begin
        if (rel_done) begin
          state_nxt = cpf_pkg::CPF_NORMAL;
        end
      end
      cpf_pkg::CPF_CHG_OC: begin
        if (rel_done) begin
          state_nxt = cpf_pkg::CPF_NORMAL;
        end
      end
      cpf_pkg::CPF_ZERO_V: begin
        if (uvr_in || !ctrl_zv_en_r) begin
          state_nxt = cpf_pkg::CPF_NORMAL;
        end
      end
      default: begin
        state_nxt = cpf_pkg::CPF_NORMAL;
      end
    endcase
  end

  // mode register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r <= cpf_pkg::CPF_NORMAL;
    end else begin
      state_r <= state_nxt;
    end
  end

  // switch and pull-down drive, registered from the next mode
  // pins move on the same edge as the mode register, never behind it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      charge_switch_o <= 1'b1;
      discharge_switch_o <= 1'b1;
      sense_pulldown_o <= 1'b0;
    end else begin
      case (state_nxt)
        cpf_pkg::CPF_NORMAL: begin
          charge_switch_o <= 1'b1;
          discharge_switch_o <= 1'b1;
          sense_pulldown_o <= 1'b0;
        end
        cpf_pkg::CPF_SHORT: begin
          charge_switch_o <= 1'b1;
          discharge_switch_o <= 1'b0;
          sense_pulldown_o <= 1'b1;
        end
        cpf_pkg::CPF_CHG_OC: begin
          charge_switch_o <= 1'b0;
          discharge_switch_o <= 1'b1;
          sense_pulldown_o <= 1'b0;
        end
        default: begin
          charge_switch_o <= chg_det;
          discharge_switch_o <= 1'b0;
          sense_pulldown_o <= 1'b0;
        end
      endcase
    end
  end

  // ==========================================================
  // events
  logic [`CPF_EV_W-1:0] ev;
  logic [`CPF_EV_W-1:0] irq_stat_r;
  logic [`CPF_EV_W-1:0] irq_mask_r;
  logic chg_mode;

  // one-cycle pulses, one enter and one leave bit per protection mode, one bit per change
  assign chg_mode = state_nxt != state_r;
  assign ev[`CPF_EV_SC_DET] = chg_mode && state_nxt == cpf_pkg::CPF_SHORT;
  assign ev[`CPF_EV_SC_REL] = chg_mode && state_r == cpf_pkg::CPF_SHORT;
  assign ev[`CPF_EV_OC_DET] = chg_mode && state_nxt == cpf_pkg::CPF_CHG_OC;
  assign ev[`CPF_EV_OC_REL] = chg_mode && state_r == cpf_pkg::CPF_CHG_OC;
  assign ev[`CPF_EV_ZV_ENT] = chg_mode && state_nxt == cpf_pkg::CPF_ZERO_V;
  assign ev[`CPF_EV_ZV_EXIT] = chg_mode && state_r == cpf_pkg::CPF_ZERO_V;

  // ==========================================================
  // wishbone slave, ack one cycle after the request
  logic ack_r;
  logic req;
  logic wr_take;
  logic rd_take;
  logic [31:0] rd_nxt;
  logic [`CPF_EV_W-1:0] stat_clr;

  // taken and completed on the edge where ack is high
  assign req = wb_cyc_i && wb_stb_i;
  assign wr_take = req && ack_r && wb_we_i;
  assign rd_take = req && ack_r && !wb_we_i;
  assign wb_ack_o = ack_r;

  // bits returned by the read now completing, the only ones it clears
  assign stat_clr = wb_dat_o[`CPF_EV_W-1:0];

  // ack pulse, dropped the cycle after it is given
  // a strobe held high is answered every other cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= req && !ack_r;
    end
  end

  // read mux, unmapped offsets read zero
  always_comb begin
    rd_nxt = 32'h0000_0000;
    case (wb_adr_i)
      `CPF_OFS_CTRL: rd_nxt[`CPF_CTRL_ZV_EN] = ctrl_zv_en_r;
      `CPF_OFS_STATUS: begin
        rd_nxt[`CPF_ST_MODE_HI:`CPF_ST_MODE_LO] = state_r;
        rd_nxt[`CPF_ST_CHARGE_SWITCH] = charge_switch_o;
        rd_nxt[`CPF_ST_DIS_SW] = discharge_switch_o;
        rd_nxt[`CPF_ST_PULLDN] = sense_pulldown_o;
        rd_nxt[`CPF_ST_IN_LO +: NIN] = in_r;
      end
      `CPF_OFS_IRQ_STAT: rd_nxt[`CPF_EV_W-1:0] = irq_stat_r;
      `CPF_OFS_IRQ_MASK: rd_nxt[`CPF_EV_W-1:0] = irq_mask_r;
      default: rd_nxt = 32'h0000_0000;
    endcase
  end

  // read data captured in the cycle before ack
  // held until the next request, so it stands while ack is high
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (req && !ack_r) begin
      wb_dat_o <= rd_nxt;
    end
  end

  // control and mask writes, low byte lane
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_zv_en_r <= 1'(`CPF_CTRL_RST);
      irq_mask_r <= `CPF_IRQ_MASK_RST;
    end else if (wr_take && wb_sel_i[0]) begin
      if (wb_adr_i == `CPF_OFS_CTRL) begin
        ctrl_zv_en_r <= wb_dat_i[`CPF_CTRL_ZV_EN];
      end
      if (wb_adr_i == `CPF_OFS_IRQ_MASK) begin
        irq_mask_r <= wb_dat_i[`CPF_EV_W-1:0];
      end
    end
  end

  // sticky events; an event after the read data was captured survives the clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_stat_r <= '0;
    end else if (rd_take && wb_adr_i == `CPF_OFS_IRQ_STAT) begin
      irq_stat_r <= (irq_stat_r & ~stat_clr) | ev;
    end else begin
      irq_stat_r <= irq_stat_r | ev;
    end
  end

  // level interrupt
  assign irq_o = |(irq_stat_r & irq_mask_r);

endmodule // cpf_fsm

// *** rtl/cpf_defines.svh ***
// offsets, fields, reset values and timing counts of the protection fsm
`ifndef CPF_DEFINES_SVH
`define CPF_DEFINES_SVH

// ==========================================================
// register byte offsets
`define CPF_OFS_CTRL 4'h0
`define CPF_OFS_STATUS 4'h4
`define CPF_OFS_IRQ_STAT 4'h8
`define CPF_OFS_IRQ_MASK 4'hc

// ==========================================================
// ctrl fields
`define CPF_CTRL_ZV_EN 0
`define CPF_CTRL_RST 32'h0000_0001

// ==========================================================
// status fields
`define CPF_ST_MODE_LO 0
`define CPF_ST_MODE_HI 1
`define CPF_ST_CHARGE_SWITCH 2
`define CPF_ST_DIS_SW 3
`define CPF_ST_PULLDN 4
`define CPF_ST_IN_LO 8

// ==========================================================
// event bits, shared by irq status and irq mask
`define CPF_EV_SC_DET 0
`define CPF_EV_SC_REL 1
`define CPF_EV_OC_DET 2
`define CPF_EV_OC_REL 3
`define CPF_EV_ZV_ENT 4
`define CPF_EV_ZV_EXIT 5
`define CPF_EV_W 6
`define CPF_IRQ_MASK_RST 6'h00

// ==========================================================
// delays in microseconds, clock in mhz, counts are their exact product
`define CPF_CLK_MHZ 125
`define CPF_SC_DLY_US 250
`define CPF_DIS_REL_DLY_US 1000
`define CPF_OC_DLY_US 8000
`define CPF_OC_REL_DLY_US 1000
`define CPF_SC_DLY_CYC (`CPF_SC_DLY_US * `CPF_CLK_MHZ)
`define CPF_DIS_REL_DLY_CYC (`CPF_DIS_REL_DLY_US * `CPF_CLK_MHZ)
`define CPF_OC_DLY_CYC (`CPF_OC_DLY_US * `CPF_CLK_MHZ)
`define CPF_OC_REL_DLY_CYC (`CPF_OC_REL_DLY_US * `CPF_CLK_MHZ)

`endif

// *** rtl/cpf_pkg.sv ***
// types of the protection fsm
package cpf_pkg;

  // ==========================================================
  // protection modes
  typedef enum logic [1:0] {
    CPF_NORMAL = 2'b00,
    CPF_SHORT = 2'b01,
    CPF_CHG_OC = 2'b10,
    CPF_ZERO_V = 2'b11
  } cpf_state_t;

  // count width of every delay timer
  typedef logic [23:0] cpf_cnt_t;

endpackage

// *** tb/cpf_fsm_asserts.sv ***
// concurrent checks on the protection fsm ports
`timescale 1ns/10ps
module cpf_fsm_asserts #(
  parameter int SC_DLY_CYC = 8,
  parameter int DIS_REL_DLY_CYC = 8,
  parameter int OC_DLY_CYC = 8,
  parameter int OC_REL_DLY_CYC = 8
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic sense_ge_short_i,
  input wire logic sense_le_dis_release_i,
  input wire logic sense_le_chg_oc_i,
  input wire logic charger_present_i,
  input wire logic load_present_i,
  input wire logic cell_below_uv_i,
  input wire logic cell_ge_uv_release_i,
  input wire logic charger_ge_detect_i,
  input wire logic charge_switch_o,
  input wire logic discharge_switch_o,
  input wire logic sense_pulldown_o
);
  // one clock, checks off during reset
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ====
  // runs of each condition held unbroken
  int sc_n;
  int rel_n;
  int oc_n;
  int gone_n;
  always_ff @(posedge clk_i) begin
    sc_n <= (rst_i || !sense_ge_short_i) ? 0 : sc_n + 1;
    rel_n <= (rst_i || load_present_i || !sense_le_dis_release_i) ? 0 : rel_n + 1;
    oc_n <= (rst_i || !sense_le_chg_oc_i) ? 0 : oc_n + 1;
    gone_n <= (rst_i || charger_present_i) ? 0 : gone_n + 1;
  end
  // ====
  // zero-volt steps
  sequence s_dark;
    cell_below_uv_i [*8];
  endsequence
  sequence s_fed;
    (cell_below_uv_i && charger_ge_detect_i) [*8];
  endsequence
  sequence s_lifted;
    (cell_ge_uv_release_i && !sense_ge_short_i) [*8];
  endsequence
  // ====
  // checks
  chk_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  chk_ack_next_cycle: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing after request");
  chk_short_delay: assert property ($rose(sense_pulldown_o) |-> sc_n >= SC_DLY_CYC)
    else $error("short mode entered early");
  chk_short_fires: assert property (sc_n == SC_DLY_CYC + 8 |-> !discharge_switch_o)
    else $error("short not detected");
  chk_short_release: assert property ($fell(sense_pulldown_o) |-> rel_n >= DIS_REL_DLY_CYC)
    else $error("short released early");
  chk_oc_delay: assert property (
    $fell(charge_switch_o) && discharge_switch_o |-> oc_n >= OC_DLY_CYC)
    else $error("charge cut early");
  chk_oc_release: assert property (
    $rose(charge_switch_o) && $past(discharge_switch_o) |-> gone_n >= OC_REL_DLY_CYC)
    else $error("charge restored early");
  chk_zv_dis_off: assert property (s_dark |-> !discharge_switch_o)
    else $error("discharge on in zero-volt");
  chk_zv_charge_on: assert property (s_fed |-> charge_switch_o)
    else $error("charge off with charger");
  chk_zv_exit: assert property (s_lifted |-> discharge_switch_o || sense_pulldown_o)
    else $error("zero-volt not left");
endmodule // cpf_fsm_asserts

bind cpf_fsm cpf_fsm_asserts #(.SC_DLY_CYC(SC_DLY_CYC), .DIS_REL_DLY_CYC(DIS_REL_DLY_CYC),
  .OC_DLY_CYC(OC_DLY_CYC), .OC_REL_DLY_CYC(OC_REL_DLY_CYC)) u_chk (.clk_i(clk_i),
  .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
  .sense_ge_short_i(sense_ge_short_i), .sense_le_dis_release_i(sense_le_dis_release_i),
  .sense_le_chg_oc_i(sense_le_chg_oc_i), .charger_present_i(charger_present_i),
  .load_present_i(load_present_i), .cell_below_uv_i(cell_below_uv_i),
  .cell_ge_uv_release_i(cell_ge_uv_release_i), .charger_ge_detect_i(charger_ge_detect_i),
  .charge_switch_o(charge_switch_o), .discharge_switch_o(discharge_switch_o),
  .sense_pulldown_o(sense_pulldown_o));

// *** tb/cpf_pack_model.sv ***
// charger, load and cell seen from the pack terminals
`timescale 1ns/10ps
module cpf_pack_model (
  input wire logic clk_i,
  input wire logic load_on_i,
  input wire logic chg_on_i,
  input wire logic short_i,
  input wire logic over_chg_i,
  input wire logic cell_low_i,
  output logic sense_ge_short_o,
  output logic sense_le_dis_release_o,
  output logic sense_le_chg_oc_o,
  output logic charger_present_o,
  output logic load_present_o,
  output logic cell_below_uv_o,
  output logic cell_ge_uv_release_o,
  output logic charger_ge_detect_o
);
  // ====
  // comparator levels follow the pack each edge
  always_ff @(posedge clk_i) begin
    sense_ge_short_o <= load_on_i && short_i;
    sense_le_dis_release_o <= !(load_on_i && short_i);
    sense_le_chg_oc_o <= chg_on_i && over_chg_i; // sense lifts once charger leaves
    charger_present_o <= chg_on_i;
    load_present_o <= load_on_i;
    cell_below_uv_o <= cell_low_i;
    cell_ge_uv_release_o <= !cell_low_i;
    charger_ge_detect_o <= chg_on_i;
  end
endmodule // cpf_pack_model

// *** tb/tb_top.sv ***
// self-checking bench for the protection fsm
`timescale 1ns/10ps
module tb_top;
  localparam int SC = 8;
  localparam int DR = 10;
  localparam int OC = 12;
  localparam int OR = 10;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [3:0] adr = 4'h0;
  logic [31:0] dat = 32'h0;
  logic [31:0] rdat;
  logic [63:0] e;
  logic ack, charge_switch, dis_sw, pd, irq;
  logic ld = 1'b0, chg = 1'b0, sc = 1'b0, oc = 1'b0, lo = 1'b0;
  logic s_ge, s_rel, s_oc, c_pr, l_pr, c_lo, c_ok, c_det;
  logic [63:0] q[$];
  int errors = 0;
  int cmp_count = 0;

  // ====
  // design and pack side
  cpf_fsm #(.SC_DLY_CYC(SC), .DIS_REL_DLY_CYC(DR), .OC_DLY_CYC(OC),
    .OC_REL_DLY_CYC(OR)) u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .sense_ge_short_i(s_ge),
    .sense_le_dis_release_i(s_rel), .sense_le_chg_oc_i(s_oc), .charger_present_i(c_pr),
    .load_present_i(l_pr), .cell_below_uv_i(c_lo), .cell_ge_uv_release_i(c_ok),
    .charger_ge_detect_i(c_det), .charge_switch_o(charge_switch), .discharge_switch_o(dis_sw),
    .sense_pulldown_o(pd), .irq_o(irq));
  cpf_pack_model u_pack (.clk_i(clk_i), .load_on_i(ld), .chg_on_i(chg), .short_i(sc),
    .over_chg_i(oc), .cell_low_i(lo), .sense_ge_short_o(s_ge), .sense_le_dis_release_o(s_rel),
    .sense_le_chg_oc_o(s_oc), .charger_present_o(c_pr), .load_present_o(l_pr),
    .cell_below_uv_o(c_lo), .cell_ge_uv_release_o(c_ok), .charger_ge_detect_o(c_det));

  // ====
  // clock and compare tasks
  initial forever #4 clk_i = ~clk_i;
  task automatic cmp_rd(input logic [31:0] x, input logic [31:0] g);
    cmp_count++;
    if (g !== x) begin
      errors++;
      $display("unexpected %0t read exp %h got %h", $time, x, g);
    end
  endtask
  task automatic cmp_pin(input logic x);
    @(negedge clk_i);
    cmp_count++;
    if (irq !== x) begin
      errors++;
      $display("unexpected %0t pin exp %h got %h", $time, x, irq);
    end
  endtask
  task automatic cmp_sw(input logic [2:0] x);
    @(negedge clk_i);
    cmp_count++;
    if ({pd, dis_sw, charge_switch} !== x) begin
      errors++;
      $display("unexpected %0t switches exp %h got %h", $time, x, {pd, dis_sw, charge_switch});
    end
  endtask
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d,
    input logic [31:0] m);
    if (!w) q.push_back({m, d});
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    do @(posedge clk_i); while (ack !== 1'b1);
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic w(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic wrap_up();
    $display("errors %0d compares %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // ====
  // read answers against the oldest note
  always @(posedge clk_i) begin
    if (ack === 1'b1 && we === 1'b0 && q.size() > 0) begin
      e = q.pop_front();
      cmp_rd(e[31:0], rdat & e[63:32]);
    end
  end

  // ====
  // watchdog
  initial begin
    w(5000);
    errors++;
    wrap_up();
  end

  // ====
  // main sequence
  initial begin
    void'($urandom(32'hed353148));
    w(2);
    rst_i <= 1'b0;
    w(4);
    wb(0, 4'h0, 32'h1, 32'hffffffff);
    wb(1, 4'h0, 32'h0, 32'h0);
    wb(0, 4'h0, 32'h0, 32'hffffffff);
    wb(1, 4'h0, 32'h1, 32'h0);
    wb(0, 4'h4, 32'h0c, 32'h1f);
    cmp_sw(3'b011);
    wb(0, 4'h2, 32'h0, 32'hffffffff);
    wb(1, 4'hc, 32'h3f, 32'h0);
    ld <= 1'b1;
    repeat (3) begin
      sc <= 1'b1;
      w($urandom_range(SC - 1, 1));
      sc <= 1'b0;
      w(4);
    end
    wb(0, 4'h4, 32'h0c, 32'h1f);
    sc <= 1'b1;
    w(SC + 10);
    wb(0, 4'h4, 32'h15, 32'h1f);
    cmp_sw(3'b101);
    wb(0, 4'h8, 32'h01, 32'h3f);
    ld <= 1'b0;
    sc <= 1'b0;
    w(DR + 10);
    wb(0, 4'h4, 32'h0c, 32'h1f);
    cmp_sw(3'b011);
    wb(0, 4'h8, 32'h02, 32'h3f);
    chg <= 1'b1;
    oc <= 1'b1;
    w(OC + 10);
    wb(0, 4'h4, 32'h0a, 32'h1f);
    cmp_sw(3'b010);
    wb(0, 4'h8, 32'h04, 32'h3f);
    chg <= 1'b0;
    w(OR + 10);
    oc <= 1'b0;
    wb(0, 4'h4, 32'h0c, 32'h1f);
    cmp_sw(3'b011);
    wb(0, 4'h8, 32'h08, 32'h3f);
    wb(1, 4'hc, 32'h1f, 32'h0);
    lo <= 1'b1;
    w(10);
    wb(0, 4'h4, 32'h03, 32'h1f);
    cmp_sw(3'b000);
    wb(0, 4'h8, 32'h10, 32'h3f);
    chg <= 1'b1;
    w(10);
    cmp_sw(3'b001);
    wb(0, 4'h4, 32'h07, 32'h1f);
    lo <= 1'b0;
    w(10);
    wb(0, 4'h4, 32'h0c, 32'h1f);
    cmp_sw(3'b011);
    cmp_pin(1'b0);
    wb(1, 4'hc, 32'h3f, 32'h0);
    cmp_pin(1'b1);
    wb(0, 4'h8, 32'h20, 32'h3f);
    cmp_pin(1'b0);
    w(4);
    wrap_up();
  end
endmodule // tb_top
